//--- logic/sps_pkg.sv
// shared constants for the stepper phase sequencer
`default_nettype none
package sps_pkg;
  localparam int SPS_POS_W = 32;
  localparam int SPS_RATE_W = 16;
  localparam logic [7:0] SPS_NV_COUNT_ADDR = 8'h93;   // location 147
  localparam logic [7:0] SPS_NV_FIRST_ADDR = 8'h94;   // location 148
  localparam logic [7:0] SPS_NV_LAST_ADDR = 8'h9B;    // location 155
  localparam logic [3:0] SPS_USER_MIN = 4'h2;
  localparam logic [3:0] SPS_USER_MAX = 4'h8;
  localparam logic [2:0] SPS_IDX_RST = 3'h0;
  localparam logic [SPS_POS_W-1:0] SPS_POS_RST = 32'h0000_0000;
  localparam logic [3:0] SPS_PHASE_OFF = 4'hF;
  localparam logic [3:0] SPS_PULSE_CYC = 4'h8;
  localparam logic [SPS_RATE_W-1:0] SPS_RAMP_DIV_RST = 16'h0100;
  localparam int SPS_SYNC_STAGES = 2;
  typedef logic [3:0] sps_pat_t;
  typedef sps_pat_t [7:0] sps_table_t;
  localparam sps_table_t SPS_FULL_STEP_TABLE = {4'h6, 4'h5, 4'h9, 4'hA, 4'h6, 4'h5, 4'h9, 4'hA};
  localparam sps_table_t SPS_HALF_STEP_TABLE = {4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8, 4'hA};
  localparam sps_table_t SPS_WAVE_DRIVE_TABLE = {4'h2, 4'h4, 4'h1, 4'h8, 4'h2, 4'h4, 4'h1, 4'h8};
  localparam sps_table_t SPS_BINARY_TRANSLATOR_TABLE =
    {4'hE, 4'h4, 4'hA, 4'h2, 4'hC, 4'hC, 4'h8, 4'h0};
  localparam sps_pat_t SPS_RES4_PAT = 4'h2;
  localparam sps_pat_t SPS_RES5_PAT = 4'h3;
  localparam sps_pat_t SPS_RES6_PAT = 4'hA;
  localparam sps_pat_t SPS_RES7_PAT = 4'h6;
  typedef enum logic [1:0] {
    SPS_INIT_CNT = 2'b00,
    SPS_INIT_TBL = 2'b01,
    SPS_INIT_DONE = 2'b11
  } sps_init_t;
endpackage
`default_nettype wire

//--- logic/sps_rate.sv
// step-rate generator with ramp toward a target period
`default_nettype none
module sps_rate #(
  parameter int RW = 16
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // clock enable
  input wire logic run, // stepping wanted
  input wire logic [RW-1:0] target_period, // commanded period, cycles
  input wire logic [RW-1:0] start_period, // initial (slowest) period
  input wire logic [RW-1:0] accel_div, // ramp slope up
  input wire logic [RW-1:0] decel_div, // ramp slope down
  output logic step_tick, // one-cycle step request
  output logic [RW-1:0] cur_period // present period
);
  import sps_pkg::*;
  logic [RW-1:0] cnt_q, slope_q;
  wire faster = cur_period > target_period;
  wire slower = cur_period < target_period;
  wire [RW-1:0] slope = faster ? accel_div : decel_div;
  wire period_end = cnt_q >= cur_period;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      slope_q <= '0;
      cur_period <= '1;
      step_tick <= 1'b0;
    end else if (clk_en) begin
      step_tick <= run && period_end;
      if (!run) begin
        cnt_q <= '0;
        cur_period <= start_period;
      end else if (period_end) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
      // ramp one period unit every slope+1 ticks, either direction
      if (run && (faster || slower)) begin
        if (slope_q >= slope) begin
          slope_q <= '0;
          cur_period <= faster ? cur_period - 1'b1 : cur_period + 1'b1;
        end else begin
          slope_q <= slope_q + 1'b1;
        end
      end
    end
  end
endmodule // sps_rate
`default_nettype wire

//--- logic/sps_sync.sv
// two-flop synchroniser for a bus of asynchronous inputs
`default_nettype none
module sps_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // clock enable
  input wire logic [W-1:0] rst_val, // value held in reset
  input wire logic [W-1:0] async_in, // pin inputs
  output logic [W-1:0] sync_out // synchronised copy
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= rst_val;
      sync_out <= rst_val;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sps_sync
`default_nettype wire

//--- logic/sps_top.sv
// stepper phase sequencer: tables, jog, position, trip, step/dir outputs
// Functional notes
// RL1: resolution 0 plays the full-step pattern twice
// RL2: resolution 1 plays the eight half-step states
// RL3: resolution 2 plays one-phase wave drive
// RL4: resolution 3 plays the binary translator sequence
// RL5: resolutions 4-7 hold fixed reserved patterns
// RL6: user length read from location 147, 2-8
// RL7: user states from 148-155, start at first
// RL8: user value 0 all off, 15 all on
// RL9: plus step advances index, wraps to one; the code wraps the index to 0, the first state
// RL10: minus step retreats index, wraps to last
// RL11: user table loads only during reset init
// RL12: direction, enable and step pulse outputs provided
// RL13: reset input high holds device in reset
// RL14: in reset all outputs high, off; the code holds position, trip_hit, go_start, nv_rd, init_done low
// RL15: jog and go ignored until init done
// RL16: two jog inputs, two selectable jog speeds
// RL17: position counter updates on every step
// RL18: trip compare fires action on position match
// RL19: ramp rate up or down, separate decel
// RL20: user bit n drives phase output n
`default_nettype none
module sps_top #(
  parameter int POS_W = sps_pkg::SPS_POS_W,
  parameter int RW = sps_pkg::SPS_RATE_W
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low
  input wire logic [2:0] resolution, // table select 0..7
  input wire logic user_mode, // use the stored user table
  input wire logic nv_ack, // nv read data valid
  input wire logic [7:0] nv_rdata, // nv read data
  input wire logic jog_plus_n, // pin: jog plus, low active
  input wire logic jog_minus_n, // pin: jog minus, low active
  input wire logic jog_fast_n, // pin: jog speed select, low = fast
  input wire logic go_n, // pin: go, low pulse
  input wire logic step_req, // move one step, pulse
  input wire logic step_dir, // direction of step_req, 1 = plus
  input wire logic motor_enable, // drive enable
  input wire logic [RW-1:0] jog_slow_period, // jog speed 0 period
  input wire logic [RW-1:0] jog_fast_period, // jog speed 1 period
  input wire logic [RW-1:0] start_period, // initial velocity period
  input wire logic [RW-1:0] accel_div, // accel slope
  input wire logic [RW-1:0] decel_div, // decel slope
  input wire logic [POS_W-1:0] trip_pos, // trip position
  input wire logic trip_arm, // enable trip compare
  input wire logic [5:0] trip_port_val, // port value, written inverted on trip
  input wire logic [RW-1:0] trip_period, // jog period after trip
  output logic nv_rd, // nv read strobe
  output logic [7:0] nv_addr, // nv address
  output logic [3:0] phase_n, // phase outputs, low = on
  output logic dir_out, // translator direction
  output logic enable_n, // translator enable, low = on
  output logic step_n, // translator step pulse, low
  output logic [POS_W-1:0] position, // position counter
  output logic trip_hit, // trip match pulse
  output logic [5:0] port_out, // general port image
  output logic go_start, // program start pulse
  output logic init_done // initialisation complete
);
  import sps_pkg::*;

  // pins pass two flops; reset value is the idle high level
  logic [3:0] pins_s;
  sps_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .rst_val(4'hF),
    .async_in({go_n, jog_fast_n, jog_minus_n, jog_plus_n}),
    .sync_out(pins_s)
  );

  sps_init_t init_q, init_d;
  logic [3:0] ulen_q;
  logic [2:0] uidx_q;
  logic [2:0] idx_q;
  sps_table_t user_q;
  logic go_s_q;
  logic pulse_act_q;
  logic [3:0] pulse_q;
  logic trip_lock_q;
  logic trip_mode_q;

  wire active = init_q == SPS_INIT_DONE; // [RL15]
  wire jog_p = active && !pins_s[0]; // [RL15]
  wire jog_m = active && !pins_s[1];
  wire jogging = jog_p ^ jog_m;
  wire go_fall = active && go_s_q && !pins_s[3]; // [RL15]

  // jog speed choice; after a trip the jog period changes to the trip period
  wire [RW-1:0] jog_target = trip_mode_q ? trip_period :
    (!pins_s[2] ? jog_fast_period : jog_slow_period); // [RL16] [RL18]
  logic jog_tick;
  sps_rate #(.RW(RW)) u_rate (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run(jogging),
    .target_period(jog_target),
    .start_period(start_period),
    .accel_div(accel_div),
    .decel_div(decel_div),
    .step_tick(jog_tick),
    .cur_period()
  ); // [RL19]

  // a step from jog wins over a bus step in the same cycle
  // a tick landing as the jog pin is released is dropped, so it cannot step the wrong way
  wire jog_step = jog_tick && jogging;
  wire do_step = active && (jog_step || step_req) && !pulse_act_q; // [RL17]
  wire step_plus = jog_step ? jog_p : step_dir;

  // user length outside 2..8 clamps to the nearest legal length
  wire [3:0] nv_len = nv_rdata[3:0];
  wire [3:0] len_clamped = (nv_rdata > 8'h08) ? SPS_USER_MAX :
    ((nv_len < SPS_USER_MIN) ? SPS_USER_MIN : nv_len); // [RL6]
  wire [2:0] last_idx = user_mode ? 3'(ulen_q - 4'h1) : 3'h7;
  wire [2:0] idx_inc = (idx_q == last_idx) ? SPS_IDX_RST : idx_q + 3'h1; // [RL9]
  wire [2:0] idx_dec = (idx_q == SPS_IDX_RST) ? last_idx : idx_q - 3'h1; // [RL10]
  wire [2:0] idx_next = step_plus ? idx_inc : idx_dec;

  // pattern bits are listed phase 3 .. phase 0, so bit n feeds phase n
  logic [3:0] pattern;
  always_comb begin
    pattern = SPS_PHASE_OFF;
    if (user_mode) begin
      pattern = user_q[idx_q]; // [RL20]
    end else begin
      unique case (resolution)
        3'h0: pattern = SPS_FULL_STEP_TABLE[idx_q]; // [RL1]
        3'h1: pattern = SPS_HALF_STEP_TABLE[idx_q]; // [RL2]
        3'h2: pattern = SPS_WAVE_DRIVE_TABLE[idx_q]; // [RL3]
        3'h3: pattern = SPS_BINARY_TRANSLATOR_TABLE[idx_q]; // [RL4]
        3'h4: pattern = SPS_RES4_PAT; // [RL5]
        3'h5: pattern = SPS_RES5_PAT; // [RL5]
        3'h6: pattern = SPS_RES6_PAT; // [RL5]
        3'h7: pattern = SPS_RES7_PAT; // [RL5]
      endcase
    end
  end

  // a one in the pattern means phase on, which is a low pin
  wire [3:0] phase_d = active && motor_enable ? ~pattern : SPS_PHASE_OFF; // [RL8]

  wire [POS_W-1:0] pos_next = step_plus ? position + 1'b1 : position - 1'b1;
  wire trip_match = trip_arm && !trip_lock_q && (position == trip_pos); // [RL18]

  // init: read length, then the eight table slots, only after reset
  always_comb begin
    init_d = init_q;
    unique case (init_q)
      SPS_INIT_CNT: if (nv_ack) init_d = SPS_INIT_TBL;
      SPS_INIT_TBL: if (nv_ack && uidx_q == 3'h7) init_d = SPS_INIT_DONE;
      SPS_INIT_DONE: init_d = SPS_INIT_DONE;
      default: init_d = SPS_INIT_CNT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin // [RL13] [RL11]
      init_q <= SPS_INIT_CNT;
      ulen_q <= SPS_USER_MAX;
      uidx_q <= SPS_IDX_RST;
      nv_rd <= 1'b0;
      nv_addr <= SPS_NV_COUNT_ADDR;
      init_done <= 1'b0;
    end else if (clk_en) begin
      init_q <= init_d;
      init_done <= init_d == SPS_INIT_DONE;
      nv_rd <= init_d != SPS_INIT_DONE;
      if (init_q == SPS_INIT_CNT && nv_ack) begin
        ulen_q <= len_clamped; // [RL6]
        nv_addr <= SPS_NV_FIRST_ADDR;
      end
      if (init_q == SPS_INIT_TBL && nv_ack) begin
        uidx_q <= uidx_q + 3'h1;
        nv_addr <= (nv_addr == SPS_NV_LAST_ADDR) ? nv_addr : nv_addr + 8'h01; // [RL7]
      end
    end
  end

  // user table storage written only by the init walk
  genvar g;
  for (g = 0; g < 8; g++) begin : g_user
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        user_q[g] <= '0;
      end else if (clk_en && init_q == SPS_INIT_TBL && nv_ack && uidx_q == 3'(g)) begin
        user_q[g] <= nv_rdata[3:0]; // [RL7] [RL11]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin // [RL14]
      idx_q <= SPS_IDX_RST; // [RL7]
      phase_n <= SPS_PHASE_OFF;
      dir_out <= 1'b1;
      enable_n <= 1'b1;
      step_n <= 1'b1;
      pulse_act_q <= 1'b0;
      pulse_q <= '0;
      position <= SPS_POS_RST;
      go_s_q <= 1'b1;
      go_start <= 1'b0;
      trip_hit <= 1'b0;
      trip_lock_q <= 1'b0;
      trip_mode_q <= 1'b0;
      port_out <= 6'h3F;
    end else if (clk_en) begin
      go_s_q <= pins_s[3];
      go_start <= go_fall; // [RL15]
      phase_n <= phase_d;
      enable_n <= !(active && motor_enable); // [RL12]
      if (do_step) begin
        idx_q <= idx_next; // [RL9] [RL10]
        position <= pos_next; // [RL17]
        dir_out <= step_plus; // [RL12]
        step_n <= 1'b0; // [RL12]
        pulse_act_q <= 1'b1;
        pulse_q <= SPS_PULSE_CYC;
      end else if (pulse_act_q) begin
        // step pulse held low, then high again before the next step
        if (pulse_q == 4'h0) begin
          pulse_act_q <= 1'b0;
        end else begin
          pulse_q <= pulse_q - 4'h1;
          if (pulse_q == 4'h1) step_n <= 1'b1;
        end
      end
      // one trip per arming; dropping trip_arm rearms it
      trip_hit <= trip_match; // [RL18]
      if (!trip_arm) begin
        trip_lock_q <= 1'b0;
        trip_mode_q <= 1'b0;
      end else if (trip_match) begin
        trip_lock_q <= 1'b1;
        trip_mode_q <= 1'b1; // [RL18]
        port_out <= ~trip_port_val; // [RL18]
      end
    end
  end
endmodule // sps_top
`default_nettype wire

//--- verif/sps_monitor.sv
// concurrent checks on the stepper phase sequencer ports
`default_nettype none
module sps_monitor #(
  parameter int POS_W = 32
) (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [3:0] phase_n, // phases
  input wire logic enable_n, // enable
  input wire logic step_n, // step pulse
  input wire logic dir_out, // direction
  input wire logic [POS_W-1:0] position, // position
  input wire logic [POS_W-1:0] trip_pos, // trip point
  input wire logic trip_arm, // trip armed
  input wire logic trip_hit, // trip pulse
  input wire logic go_start, // go pulse
  input wire logic init_done, // init done
  input wire logic nv_rd, // nv read
  input wire logic nv_ack, // nv ack
  input wire logic [7:0] nv_addr // nv address
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_rst_outs_off: assert property (
    $past(sys_rst) |-> phase_n == 4'hF && enable_n && step_n && !init_done)
    else $error("outputs not off after reset");
  a_step_width: assert property (
    $fell(step_n) |-> !step_n [*8] ##1 step_n) else $error("step pulse width wrong");
  a_pos_follows: assert property (
    $fell(step_n) |-> position == (dir_out ? $past(position) + 1'b1 : $past(position) - 1'b1))
    else $error("position not moved by one step");
  a_pos_quiet: assert property (
    $changed(position) |-> $fell(step_n)) else $error("position moved without step");
  a_init_gate: assert property (
    !init_done |-> step_n && !go_start) else $error("activity before init done");
  a_go_single: assert property (
    go_start |=> !go_start) else $error("go pulse too long");
  a_trip_cause: assert property (
    trip_hit |-> $past(position) == $past(trip_pos) && $past(trip_arm))
    else $error("trip without match");
  a_nv_idle: assert property (
    $past(init_done) && init_done |-> !nv_rd) else $error("table read after init");
  a_nv_order: assert property (
    nv_rd && nv_ack && nv_addr != 8'h9B |=> nv_addr == $past(nv_addr) + 8'h01)
    else $error("nv address order wrong");
  c_step: cover property ($fell(step_n));
  c_trip: cover property (trip_hit);
  c_init: cover property ($rose(init_done));
endmodule // sps_monitor
bind sps_top sps_monitor #(.POS_W(POS_W)) mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .phase_n(phase_n), .enable_n(enable_n),
  .step_n(step_n), .dir_out(dir_out), .position(position), .trip_pos(trip_pos),
  .trip_arm(trip_arm), .trip_hit(trip_hit), .go_start(go_start), .init_done(init_done),
  .nv_rd(nv_rd), .nv_ack(nv_ack), .nv_addr(nv_addr)
);
`default_nettype wire

//--- verif/sps_nv_model.sv
// behavioural nonvolatile store answering the sequencer's start-up reads
`default_nettype none
module sps_nv_model (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic nv_rd, // read strobe
  input wire logic [7:0] nv_addr, // address
  output logic nv_ack, // data valid pulse
  output logic [7:0] nv_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  logic slow_q;
  // answers alternate prompt and slow; data toggles when not valid so stale bytes never pass
  always_ff @(posedge sys_clk) begin
    nv_ack <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (sys_rst) begin
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      nv_rdata <= 8'h5A;
    end else if (nv_rd && !nv_ack) begin
      if (wait_q == {slow_q, slow_q}) begin
        nv_ack <= 1'b1;
        nv_rdata <= mem[nv_addr];
        wait_q <= 2'h0;
        slow_q <= ~slow_q;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule // sps_nv_model
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the stepper phase sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sps_pkg::*;
  logic clk, sys_rst = 1'b1, user_mode = 1'b1, go_n = 1'b1, step_req = 1'b0, step_dir = 1'b1;
  logic jog_plus_n = 1'b1, jog_minus_n = 1'b1, jog_fast_n = 1'b1, trip_arm = 1'b0;
  logic motor_en = 1'b1;
  logic nv_rd, nv_ack, trip_hit, go_start, init_done, enable_n, step_n, dir_out;
  logic [2:0] resolution = 3'h0;
  logic [5:0] trip_port_val = 6'h00, port_out;
  logic [7:0] nv_addr, nv_rdata;
  logic [15:0] p_slow, p_fast, p_start, p_acc;
  logic [SPS_POS_W-1:0] trip_pos = '1, position, pos;
  logic [3:0] phase_n, uv [8], nv_v [8];
  int err_total = 0, compares = 0, cyc = 0, hits = 0, gos = 0, idx, ulen, nlen;
  logic [31:0] rows [8] = '{32'hA956A956, 32'hA8915462, 32'h81428142, 32'h08CC2A4E,
    32'h22222222, 32'h33333333, 32'hAAAAAAAA, 32'h66666666};
  sps_top uut (
    .sys_clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .resolution(resolution),
    .user_mode(user_mode), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .jog_plus_n(jog_plus_n),
    .jog_minus_n(jog_minus_n), .jog_fast_n(jog_fast_n), .go_n(go_n), .step_req(step_req),
    .step_dir(step_dir), .motor_enable(motor_en), .jog_slow_period(p_slow),
    .jog_fast_period(p_fast), .start_period(p_start), .accel_div(p_acc), .decel_div(16'h0002),
    .trip_pos(trip_pos), .trip_arm(trip_arm), .trip_port_val(trip_port_val),
    .trip_period(16'h0020), .nv_rd(nv_rd), .nv_addr(nv_addr), .phase_n(phase_n),
    .dir_out(dir_out), .enable_n(enable_n), .step_n(step_n), .position(position),
    .trip_hit(trip_hit), .port_out(port_out), .go_start(go_start), .init_done(init_done)
  );
  sps_nv_model nv (
    .sys_clk(clk), .sys_rst(sys_rst), .nv_rd(nv_rd), .nv_addr(nv_addr), .nv_ack(nv_ack),
    .nv_rdata(nv_rdata)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic stop_test;
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hits <= hits + (trip_hit === 1'b1);
    gos <= gos + (go_start === 1'b1);
    if (cyc == 8000) begin
      $display("[FAIL] %0t timeout", $time);
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      err_total++;
    end
  endtask
  // phase lines are low when on, so callers invert with an xor
  function automatic logic [3:0] expv();
    if (user_mode) return uv[idx];
    return rows[resolution][31 - 4 * idx -: 4];
  endfunction
  task automatic fill_nv;
    nlen = 2 + $urandom % 7;
    nv.mem[8'h93] = 8'(nlen);
    for (int i = 0; i < 8; i++) begin
      nv_v[i] = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      nv.mem[8'h94 + i] = {4'h0, nv_v[i]};
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk({phase_n, enable_n, step_n, dir_out, init_done}, 8'hFE, "reset outputs");
    @(posedge clk);
    sys_rst <= 1'b0;
    for (int n = 0; n < 400 && init_done !== 1'b1; n++) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
    ulen = nlen;
    uv = nv_v;
    idx = 0;
    pos = '0;
    chk(phase_n, expv() ^ 4'hF, "first state");
    chk(enable_n, 1'b0, "enable after init");
  endtask
  task automatic step(input logic d);
    int n;
    @(posedge clk);
    step_req <= 1'b1;
    step_dir <= d;
    @(posedge clk);
    step_req <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    n = user_mode ? ulen : 8;
    idx = d ? (idx + 1) % n : (idx + n - 1) % n;
    pos = d ? pos + 1'b1 : pos - 1'b1;
    chk(phase_n, expv() ^ 4'hF, "phase");
    chk(position, pos, "position");
  endtask
  initial begin
    void'($urandom(83));
    p_slow <= 16'h30 + 16'($urandom % 32);
    p_fast <= 16'h18 + 16'($urandom % 16);
    p_start <= 16'h50 + 16'($urandom % 32);
    p_acc <= 16'($urandom % 4);
    fill_nv();
    do_reset();
    repeat (12) step(1'($urandom));
    fill_nv();
    repeat (4) step(1'($urandom));
    do_reset();
    repeat (6) step(1'($urandom));
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      user_mode <= 1'b0;
      resolution <= 3'(r);
      repeat (8) step(1'b1);
      step(1'b0);
    end
    @(posedge clk);
    trip_pos <= pos + 2;
    trip_port_val <= 6'($urandom);
    trip_arm <= 1'b1;
    repeat (3) step(1'b1);
    chk(hits, 1, "trip count");
    chk(port_out, trip_port_val ^ 6'h3F, "trip port");
    @(posedge clk);
    trip_arm <= 1'b0;
    go_n <= 1'b0;
    repeat (3) @(posedge clk);
    go_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(gos, 1, "go pulse");
    for (int d = 0; d < 2; d++) begin
      pos = position;
      @(posedge clk);
      jog_minus_n <= d[0];
      jog_plus_n <= !d[0];
      jog_fast_n <= 1'($urandom);
      repeat (400) @(posedge clk);
      jog_minus_n <= 1'b1;
      jog_plus_n <= 1'b1;
      repeat (40) @(posedge clk);
      #1;
      chk(d[0] ? $signed(position) > $signed(pos) : $signed(position) < $signed(pos), 1,
        "jog");
    end
    // dropping the drive enable must release every phase and the translator enable
    @(posedge clk);
    motor_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({phase_n, enable_n}, 5'h1F, "motor off");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
